// File: bench/header_partner.sv
`timescale 1ns/1ps
module header_partner (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic translator_enable,
  input wire logic [17:0] dev_o,
  input wire logic [17:0] dev_oe,
  input wire logic [17:0] ext_o,
  input wire logic [17:0] ext_oe,
  input wire logic case_opened,
  output logic [17:0] line_lvl,
  output logic case_open_n
);
  logic [17:0] float_r;
  logic [17:0] drv_en;
  // Undriven lines wander so a stale value cannot pass
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      float_r <= 18'h15555;
    end else begin
      float_r <= ~float_r;
    end
  end
  assign drv_en = dev_oe & {18{translator_enable}};
  assign line_lvl = (drv_en & dev_o) | (~drv_en & ext_oe & ext_o) | (~drv_en & ~ext_oe & float_r);
  assign case_open_n = ~case_opened;
endmodule : header_partner

// File: bench/power_state_indicators_and_gpio_header_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module power_state_indicators_and_gpio_header_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic irq;
  gpio_hdr_pkg::pwr_state_t pwr_state = gpio_hdr_pkg::PWR_ACTIVE;
  logic core_ind, cpu_ind, deep_ind, case_open_n, translator_enable, case_opened = 1'b0;
  logic [17:0] line_lvl, line_o, line_oe, ext_o = 18'h0, ext_oe = 18'h0;
  logic [7:0] kb_col_o = 8'h0, kb_col_oe = 8'h0, kb_col_i;
  logic [13:0] kb_row_o = 14'h0, kb_row_oe = 14'h0, kb_row_i;
  logic [31:0] d;
  logic [17:0] f, lvl, g;
  int miscompares = 0;
  int checks_done = 0;
  typedef struct packed {logic [1:0] st; logic [2:0] ind;} prow_t;
  prow_t rows [6] = '{'{2'h0, 3'h6}, '{2'h2, 3'h1}, '{2'h1, 3'h4}, '{2'h3, 3'h0}, '{2'h0, 3'h6}, '{2'h1, 3'h4}};
  always #20 sys_clk = ~sys_clk;
  power_state_indicators_and_gpio_header i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .pwr_state(pwr_state), .core_rail_indicator(core_ind), .cpu_rail_indicator(cpu_ind),
    .deep_sleep_indicator(deep_ind), .case_open_n(case_open_n), .translator_enable(translator_enable),
    .general_line_i(line_lvl), .general_line_o(line_o), .general_line_oe(line_oe), .kb_col_o(kb_col_o),
    .kb_col_oe(kb_col_oe), .kb_col_i(kb_col_i), .kb_row_o(kb_row_o), .kb_row_oe(kb_row_oe), .kb_row_i(kb_row_i));
  header_partner i_partner (.sys_clk(sys_clk), .rst(rst), .translator_enable(translator_enable), .dev_o(line_o),
    .dev_oe(line_oe), .ext_o(ext_o), .ext_oe(ext_oe), .case_opened(case_opened), .line_lvl(line_lvl),
    .case_open_n(case_open_n));
  //////////////////////////////////////////////////////////////////
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge sys_clk);
    #1 `CHK(reg_rdata, 32'h0)
  endtask : rd_reg
  function automatic logic [17:0] kbmap(input logic [7:0] c, input logic [13:0] r);
    return {r[13:9], r[5:0], c[7:1]};
  endfunction : kbmap
  task automatic complete_run();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  //////////////////////////////////////////////////////////////////
  initial begin
    repeat (4000) @(posedge sys_clk);
    miscompares++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    `CHK({translator_enable, line_oe, irq}, 20'h0)
    `CHK({core_ind, cpu_ind, deep_ind}, 3'h0)
    rst <= 1'b0;
    rd_reg(gpio_hdr_pkg::OFS_FUNC);
    `CHK(d[17:0], 18'h0)
    $display("test reset done");
    foreach (rows[i]) begin
      @(posedge sys_clk);
      pwr_state <= gpio_hdr_pkg::pwr_state_t'(rows[i].st);
      @(posedge sys_clk);
      #1 `CHK({core_ind, cpu_ind, deep_ind}, rows[i].ind)
      rd_reg(gpio_hdr_pkg::OFS_PWR);
      `CHK(d[2:0], rows[i].ind)
    end
    $display("test power rows done");
    wr_reg(gpio_hdr_pkg::OFS_OUT, 32'h0002a5c3);
    wr_reg(gpio_hdr_pkg::OFS_DIR, 32'h0000ff0f);
    ext_o <= 18'h15a5a;
    ext_oe <= 18'h300f0;
    #1 `CHK(line_oe, 18'h0)
    wr_reg(gpio_hdr_pkg::OFS_CTRL, 32'h1);
    #1 `CHK({translator_enable, line_oe, line_o}, {1'b1, 18'h0ff0f, 18'h2a5c3})
    repeat (4) @(posedge sys_clk);
    rd_reg(gpio_hdr_pkg::OFS_IN);
    `CHK(d[17:0], 18'h1a553)
    $display("test translator done");
    @(posedge sys_clk);
    f = 18'h2b0f1;
    kb_col_o <= 8'ha4;
    kb_col_oe <= 8'hfe;
    kb_row_o <= 14'h2a5a;
    kb_row_oe <= 14'h3e3f;
    wr_reg(gpio_hdr_pkg::OFS_FUNC, {14'h0, f});
    #1 `CHK(line_o, (kbmap(8'ha4, 14'h2a5a) & f) | (18'h2a5c3 & ~f))
    `CHK(line_oe, (kbmap(8'hfe, 14'h3e3f) & f) | (18'h0ff0f & ~f))
    @(posedge sys_clk);
    kb_col_oe <= 8'h0;
    kb_row_oe <= 14'h0;
    ext_o <= 18'h2c3a5;
    ext_oe <= 18'h3ffff;
    repeat (5) @(posedge sys_clk);
    #1 lvl = (18'h0ff0f & ~f & 18'h2a5c3) | (~(18'h0ff0f & ~f) & 18'h2c3a5);
    g = lvl | ~f;
    `CHK({kb_col_i, kb_row_i}, {g[6:0], 1'b1, g[17:13], 3'h7, g[12:7]})
    $display("test alternate done");
    wr_reg(gpio_hdr_pkg::OFS_STATUS, 32'h3);
    wr_reg(gpio_hdr_pkg::OFS_MASK, 32'h1);
    case_opened <= 1'b1;
    #1 `CHK(irq, 1'b0)
    repeat (6) @(posedge sys_clk);
    #1 `CHK(irq, 1'b1)
    rd_reg(gpio_hdr_pkg::OFS_STATUS);
    `CHK(d[0], 1'b1)
    wr_reg(gpio_hdr_pkg::OFS_STATUS, 32'h1);
    #1 `CHK(irq, 1'b0)
    wr_reg(gpio_hdr_pkg::OFS_MASK, 32'h2);
    pwr_state <= gpio_hdr_pkg::PWR_DEEP_SLEEP;
    repeat (2) @(posedge sys_clk);
    #1 `CHK(irq, 1'b1)
    wr_reg(4'h9, 32'hffffffff);
    rd_reg(4'h9);
    `CHK(d, 32'h0)
    $display("test events done");
    wr_reg(gpio_hdr_pkg::OFS_FUNC, 32'h0003ffff);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 `CHK({translator_enable, line_oe, irq, core_ind, cpu_ind, deep_ind}, 23'h0)
    @(posedge sys_clk);
    rst <= 1'b0;
    rd_reg(gpio_hdr_pkg::OFS_FUNC);
    `CHK({d[17:0], translator_enable}, 19'h0)
    `CHK({core_ind, cpu_ind, deep_ind}, 3'h1)
    $display("test mid reset done");
    complete_run();
  end
endmodule : power_state_indicators_and_gpio_header_tb

// File: include/gpio_hdr_pkg.sv
package gpio_hdr_pkg;

  localparam int NUM_LINES = 18;

  // Register offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_FUNC = 4'h1;
  localparam logic [3:0] OFS_OUT = 4'h2;
  localparam logic [3:0] OFS_DIR = 4'h3;
  localparam logic [3:0] OFS_IN = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h5;
  localparam logic [3:0] OFS_MASK = 4'h6;
  localparam logic [3:0] OFS_PWR = 4'h7;

  // Control field positions
  localparam int CTRL_XLAT_EN_BIT = 0;

  // Status and mask field positions
  localparam int ST_CASE_OPEN_BIT = 0;
  localparam int ST_PWR_CHG_BIT = 1;
  localparam int ST_WIDTH = 2;

  // Reset values
  localparam logic [17:0] FUNC_RST = 18'h00000;
  localparam logic [17:0] OUT_RST = 18'h00000;
  localparam logic [17:0] DIR_RST = 18'h00000;
  localparam logic CTRL_XLAT_RST = 1'b0;
  localparam logic [1:0] ST_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;

  // Keyboard alternate map boundaries
  localparam int KB_COL_LAST_LINE = 6;
  localparam int KB_ROW_A_LAST_LINE = 12;
  localparam int KB_COL_BASE = 1;
  localparam int KB_ROW_A_BASE = 0;
  localparam int KB_ROW_B_BASE = 9;
  localparam int KB_COLS = 8;
  localparam int KB_ROWS = 14;

  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'h0,
    PWR_SUSPEND = 2'h1,
    PWR_DEEP_SLEEP = 2'h2
  } pwr_state_t;

  typedef struct packed {
    logic core_rail;
    logic cpu_rail;
    logic deep_sleep;
  } indicators_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [17:0] o;
    logic [17:0] oe;
  } line_drive_t;

endpackage : gpio_hdr_pkg

// File: rtl/power_state_indicators_and_gpio_header.sv
`timescale 1ns/1ps
// What this block does
// - Core-rail indicator high while core rail enabled
// - CPU-rail indicator high while CPU rail enabled
// - Deep-sleep indicator high in deep sleep
// - Indicators follow active, suspend, deep-sleep table
// - Case-open input reported to software
// - One translator enable gates all lines
// - Each line selectable plain or alternate
// - Lines map to keyboard columns and rows
module power_state_indicators_and_gpio_header (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  input wire gpio_hdr_pkg::pwr_state_t pwr_state,
  output logic core_rail_indicator,
  output logic cpu_rail_indicator,
  output logic deep_sleep_indicator,
  input wire logic case_open_n,
  output logic translator_enable,
  input wire logic [17:0] general_line_i,
  output logic [17:0] general_line_o,
  output logic [17:0] general_line_oe,
  input wire logic [7:0] kb_col_o,
  input wire logic [7:0] kb_col_oe,
  output logic [7:0] kb_col_i,
  input wire logic [13:0] kb_row_o,
  input wire logic [13:0] kb_row_oe,
  output logic [13:0] kb_row_i
);

  ////////////////////////////////////////////////////////////////
  gpio_hdr_pkg::reg_req_t req;
  gpio_hdr_pkg::indicators_t ind;
  gpio_hdr_pkg::line_drive_t drv;
  logic pwr_changed;
  logic [18:0] pins_sync;
  logic case_open_s;
  logic case_open_d_r;
  logic case_open_rise;
  logic [17:0] line_in_s;

  logic xlat_en_r;
  logic [17:0] func_r;
  logic [17:0] out_r;
  logic [17:0] dir_r;
  logic [1:0] status_r;
  logic [1:0] status_nxt;
  logic [1:0] mask_r;
  logic [1:0] events;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  ////////////////////////////////////////////////////////////////
  pwr_indicators u_pwr (
    .sys_clk(sys_clk),
    .rst(rst),
    .pwr_state(pwr_state),
    .ind(ind),
    .changed(pwr_changed)
  );

  assign core_rail_indicator = ind.core_rail;
  assign cpu_rail_indicator = ind.cpu_rail;
  assign deep_sleep_indicator = ind.deep_sleep;

  ////////////////////////////////////////////////////////////////
  sync2 #(.W(19)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .d({~case_open_n, general_line_i}),
    .q(pins_sync)
  );

  assign case_open_s = pins_sync[18];
  assign line_in_s = pins_sync[17:0];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      case_open_d_r <= 1'b0;
    end else begin
      case_open_d_r <= case_open_s;
    end
  end

  assign case_open_rise = case_open_s & ~case_open_d_r;

  ////////////////////////////////////////////////////////////////
  // Register write decode
  logic wr_ctrl;
  logic wr_func;
  logic wr_out;
  logic wr_dir;
  logic wr_status;
  logic wr_mask;

  assign wr_ctrl = req.wr && req.addr == gpio_hdr_pkg::OFS_CTRL;
  assign wr_func = req.wr && req.addr == gpio_hdr_pkg::OFS_FUNC;
  assign wr_out = req.wr && req.addr == gpio_hdr_pkg::OFS_OUT;
  assign wr_dir = req.wr && req.addr == gpio_hdr_pkg::OFS_DIR;
  assign wr_status = req.wr && req.addr == gpio_hdr_pkg::OFS_STATUS;
  assign wr_mask = req.wr && req.addr == gpio_hdr_pkg::OFS_MASK;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      xlat_en_r <= gpio_hdr_pkg::CTRL_XLAT_RST;
      func_r <= gpio_hdr_pkg::FUNC_RST;
      out_r <= gpio_hdr_pkg::OUT_RST;
      dir_r <= gpio_hdr_pkg::DIR_RST;
      mask_r <= gpio_hdr_pkg::MASK_RST;
    end else begin
      if (wr_ctrl) begin
        xlat_en_r <= req.wdata[gpio_hdr_pkg::CTRL_XLAT_EN_BIT];
      end
      if (wr_func) begin
        func_r <= req.wdata[17:0];
      end
      if (wr_out) begin
        out_r <= req.wdata[17:0];
      end
      if (wr_dir) begin
        dir_r <= req.wdata[17:0];
      end
      if (wr_mask) begin
        mask_r <= req.wdata[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Sticky events, set wins over write-one-clear
  assign events[gpio_hdr_pkg::ST_CASE_OPEN_BIT] = case_open_rise;
  assign events[gpio_hdr_pkg::ST_PWR_CHG_BIT] = pwr_changed;
  assign status_nxt = (status_r & ~(wr_status ? req.wdata[1:0] : 2'h0)) | events;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_r <= gpio_hdr_pkg::ST_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign irq = |(status_r & mask_r);

  ////////////////////////////////////////////////////////////////
  // Per-line function mux to keyboard matrix
  logic [17:0] alt_o;
  logic [17:0] alt_oe;

  genvar gi;
  generate
    for (gi = 0; gi < gpio_hdr_pkg::NUM_LINES; gi++) begin : g_line
      if (gi <= gpio_hdr_pkg::KB_COL_LAST_LINE) begin : g_col
        localparam int C = gi + gpio_hdr_pkg::KB_COL_BASE;
        assign alt_o[gi] = kb_col_o[C];
        assign alt_oe[gi] = kb_col_oe[C];
        assign kb_col_i[C] = func_r[gi] ? line_in_s[gi] : 1'b1;
      end else if (gi <= gpio_hdr_pkg::KB_ROW_A_LAST_LINE) begin : g_row_a
        localparam int R = gi - gpio_hdr_pkg::KB_COL_LAST_LINE - 1 + gpio_hdr_pkg::KB_ROW_A_BASE;
        assign alt_o[gi] = kb_row_o[R];
        assign alt_oe[gi] = kb_row_oe[R];
        assign kb_row_i[R] = func_r[gi] ? line_in_s[gi] : 1'b1;
      end else begin : g_row_b
        localparam int R = gi - gpio_hdr_pkg::KB_ROW_A_LAST_LINE - 1 + gpio_hdr_pkg::KB_ROW_B_BASE;
        assign alt_o[gi] = kb_row_o[R];
        assign alt_oe[gi] = kb_row_oe[R];
        assign kb_row_i[R] = func_r[gi] ? line_in_s[gi] : 1'b1;
      end
    end
  endgenerate

  // Unmapped matrix positions read idle high
  assign kb_col_i[0] = 1'b1;
  assign kb_row_i[8:6] = 3'h7;

  assign drv.o = (func_r & alt_o) | (~func_r & out_r);
  assign drv.oe = (func_r & alt_oe) | (~func_r & dir_r);

  // Translator enable gates every line buffer
  assign translator_enable = xlat_en_r;
  assign general_line_o = drv.o;
  assign general_line_oe = xlat_en_r ? drv.oe : 18'h00000;

  ////////////////////////////////////////////////////////////////
  logic [31:0] rd_mux;

  assign rd_mux =
    (req.addr == gpio_hdr_pkg::OFS_CTRL) ? {31'h0, xlat_en_r} :
    (req.addr == gpio_hdr_pkg::OFS_FUNC) ? {14'h0, func_r} :
    (req.addr == gpio_hdr_pkg::OFS_OUT) ? {14'h0, out_r} :
    (req.addr == gpio_hdr_pkg::OFS_DIR) ? {14'h0, dir_r} :
    (req.addr == gpio_hdr_pkg::OFS_IN) ? {14'h0, line_in_s} :
    (req.addr == gpio_hdr_pkg::OFS_STATUS) ? {29'h0, case_open_s, status_r} :
    (req.addr == gpio_hdr_pkg::OFS_MASK) ? {30'h0, mask_r} :
    (req.addr == gpio_hdr_pkg::OFS_PWR) ? {29'h0, ind} :
    32'h00000000;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= req.rd ? rd_mux : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Sampled reset keeps the release edge out of the attempts
  sequence deep_req_s;
    !rst && pwr_state == gpio_hdr_pkg::PWR_DEEP_SLEEP;
  endsequence

  sequence deep_ind_s;
    deep_sleep_indicator && !core_rail_indicator && !cpu_rail_indicator;
  endsequence

  sequence rd_at_s(logic [3:0] ofs);
    req.rd && req.addr == ofs;
  endsequence

  deep_sleep_out_a: assert property (@(posedge sys_clk) disable iff (rst)
    deep_req_s |=> deep_ind_s)
    else $error("deep sleep indicators wrong");

  active_core_a: assert property (@(posedge sys_clk) disable iff (rst)
    !rst && pwr_state == gpio_hdr_pkg::PWR_ACTIVE
    |=> core_rail_indicator && cpu_rail_indicator && !deep_sleep_indicator)
    else $error("active indicators wrong");

  cpu_rail_off_a: assert property (@(posedge sys_clk) disable iff (rst)
    pwr_state != gpio_hdr_pkg::PWR_ACTIVE |=> !cpu_rail_indicator)
    else $error("cpu rail indicator high outside active");

  ////////////////////////////////////////////////////////////////
  case_open_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(case_open_s) |=> status_r[gpio_hdr_pkg::ST_CASE_OPEN_BIT])
    else $error("case open event lost");

  case_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    status_r[gpio_hdr_pkg::ST_CASE_OPEN_BIT] && !(wr_status && req.wdata[gpio_hdr_pkg::ST_CASE_OPEN_BIT])
    |=> status_r[gpio_hdr_pkg::ST_CASE_OPEN_BIT])
    else $error("case open flag dropped");

  case_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    wr_status && req.wdata[gpio_hdr_pkg::ST_CASE_OPEN_BIT] && !case_open_rise
    |=> !status_r[gpio_hdr_pkg::ST_CASE_OPEN_BIT])
    else $error("case open flag not cleared");

  pwr_chg_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
    !rst && pwr_changed |=> status_r[gpio_hdr_pkg::ST_PWR_CHG_BIT])
    else $error("power change event lost");

  pwr_chg_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    status_r[gpio_hdr_pkg::ST_PWR_CHG_BIT] && !(wr_status && req.wdata[gpio_hdr_pkg::ST_PWR_CHG_BIT])
    |=> status_r[gpio_hdr_pkg::ST_PWR_CHG_BIT])
    else $error("power change flag dropped");

  ////////////////////////////////////////////////////////////////
  xlat_tristate_a: assert property (@(posedge sys_clk) disable iff (rst)
    !translator_enable |-> general_line_oe == 18'h00000)
    else $error("line driven with translator off");

  xlat_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    wr_ctrl |=> translator_enable == $past(req.wdata[gpio_hdr_pkg::CTRL_XLAT_EN_BIT]))
    else $error("translator enable write not taken");

  xlat_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    !wr_ctrl |=> $stable(translator_enable))
    else $error("translator enable changed without write");

  func_select_a: assert property (@(posedge sys_clk) disable iff (rst)
    wr_func |=> func_r == $past(req.wdata[17:0]))
    else $error("function select not taken");

  func_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    !wr_func |=> $stable(func_r))
    else $error("function select changed without write");

  plain_drive_a: assert property (@(posedge sys_clk) disable iff (rst)
    xlat_en_r |-> ((general_line_o ^ out_r) & ~func_r) == 18'h00000
      && ((general_line_oe ^ dir_r) & ~func_r) == 18'h00000)
    else $error("plain line not driven from registers");

  kb_in_plain_a: assert property (@(posedge sys_clk) disable iff (rst)
    !func_r[1] && !func_r[16] |-> kb_col_i[2] && kb_row_i[12])
    else $error("keyboard input not idle in plain mode");

  ////////////////////////////////////////////////////////////////
  kb_col_map_a: assert property (@(posedge sys_clk) disable iff (rst)
    func_r[0] && xlat_en_r |-> general_line_oe[0] == kb_col_oe[1] && general_line_o[0] == kb_col_o[1])
    else $error("line 0 not on column 1");

  kb_col_last_a: assert property (@(posedge sys_clk) disable iff (rst)
    func_r[6] && xlat_en_r |-> general_line_oe[6] == kb_col_oe[7] && general_line_o[6] == kb_col_o[7])
    else $error("line 6 not on column 7");

  kb_row_first_a: assert property (@(posedge sys_clk) disable iff (rst)
    func_r[7] && xlat_en_r |-> general_line_o[7] == kb_row_o[0] && general_line_oe[7] == kb_row_oe[0])
    else $error("line 7 not on row 0");

  kb_row_gap_a: assert property (@(posedge sys_clk) disable iff (rst)
    func_r[12] && xlat_en_r |-> general_line_o[12] == kb_row_o[5] && general_line_oe[12] == kb_row_oe[5])
    else $error("line 12 not on row 5");

  kb_row_map_a: assert property (@(posedge sys_clk) disable iff (rst)
    func_r[13] && xlat_en_r |-> general_line_o[13] == kb_row_o[9] && general_line_oe[13] == kb_row_oe[9])
    else $error("line 13 not on row 9");

  kb_row_last_a: assert property (@(posedge sys_clk) disable iff (rst)
    func_r[17] && xlat_en_r |-> general_line_o[17] == kb_row_o[13] && general_line_oe[17] == kb_row_oe[13])
    else $error("line 17 not on row 13");

  kb_in_alt_a: assert property (@(posedge sys_clk) disable iff (rst)
    func_r[6] && func_r[7] |-> kb_col_i[7] == line_in_s[6] && kb_row_i[0] == line_in_s[7])
    else $error("keyboard input not taken from line");

  ////////////////////////////////////////////////////////////////
  // Read data stands one cycle after the strobe, zero otherwise
  rd_ctrl_a: assert property (@(posedge sys_clk) disable iff (rst)
    rd_at_s(gpio_hdr_pkg::OFS_CTRL) |=> reg_rdata == {31'h0, $past(xlat_en_r)})
    else $error("control read back wrong");

  rd_func_a: assert property (@(posedge sys_clk) disable iff (rst)
    rd_at_s(gpio_hdr_pkg::OFS_FUNC) |=> reg_rdata == {14'h0, $past(func_r)})
    else $error("function read back wrong");

  rd_in_a: assert property (@(posedge sys_clk) disable iff (rst)
    rd_at_s(gpio_hdr_pkg::OFS_IN) |=> reg_rdata == {14'h0, $past(line_in_s)})
    else $error("line input read back wrong");

  rd_status_a: assert property (@(posedge sys_clk) disable iff (rst)
    rd_at_s(gpio_hdr_pkg::OFS_STATUS) |=> reg_rdata == {29'h0, $past(case_open_s), $past(status_r)})
    else $error("status read back wrong");

  rd_pwr_a: assert property (@(posedge sys_clk) disable iff (rst)
    rd_at_s(gpio_hdr_pkg::OFS_PWR) |=> reg_rdata == {29'h0, $past(ind)})
    else $error("power state read back wrong");

  rd_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
    !req.rd |=> reg_rdata == 32'h00000000)
    else $error("read data outside read cycle");

  reset_default_a: assert property (@(posedge sys_clk)
    $fell(rst) |-> func_r == 18'h00000 && !translator_enable)
    else $error("reset defaults wrong");

endmodule : power_state_indicators_and_gpio_header

// File: rtl/pwr_indicators.sv
`timescale 1ns/1ps
module pwr_indicators (
  input wire logic sys_clk,
  input wire logic rst,
  input wire gpio_hdr_pkg::pwr_state_t pwr_state,
  output gpio_hdr_pkg::indicators_t ind,
  output logic changed
);
  gpio_hdr_pkg::indicators_t ind_nxt;

  always_comb begin
    ind_nxt = '0;
    case (pwr_state)
      gpio_hdr_pkg::PWR_ACTIVE: begin
        ind_nxt.core_rail = 1'b1;
        ind_nxt.cpu_rail = 1'b1;
      end
      gpio_hdr_pkg::PWR_SUSPEND: begin
        ind_nxt.core_rail = 1'b1;
      end
      gpio_hdr_pkg::PWR_DEEP_SLEEP: begin
        ind_nxt.deep_sleep = 1'b1;
      end
      default: begin
        ind_nxt = '0;
      end
    endcase
  end

  // Registered indicator outputs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ind <= '0;
    end else begin
      ind <= ind_nxt;
    end
  end

  assign changed = (ind_nxt != ind);

  // Sampled reset keeps the release edge out of the attempts
  suspend_map_a: assert property (@(posedge sys_clk) disable iff (rst)
    !rst && pwr_state == gpio_hdr_pkg::PWR_SUSPEND |=> ind == 3'b100)
    else $error("suspend indicators wrong");
endmodule : pwr_indicators

// File: rtl/sync2.sv
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : sync2
